// ---- logic/scwc_pkg.sv ----
// Package for the sub-clock and wait control block: offsets, fields, resets, timings.
// Assumes an 8-bit register port with byte addresses and a single 200 MHz system clock.

package scwc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] SCWC_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] SCWC_OFS_CTRL1 = 8'h01;
  localparam logic [7:0] SCWC_OFS_CTRL3 = 8'h03;
  localparam logic [7:0] SCWC_OFS_FLASH = 8'h04;
  localparam logic [7:0] SCWC_OFS_VDET2 = 8'h05;
  localparam logic [7:0] SCWC_OFS_STATUS = 8'h06;
  localparam logic [7:0] SCWC_OFS_IRQ_LVL = 8'h08;
  localparam logic [7:0] SCWC_OFS_WAKE_LEN = 8'h10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SCWC_B_SUBCLK_STOP = 3;
  localparam int SCWC_B_SUBCLK_PIN_SEL = 4;
  localparam int SCWC_B_CPU_DIV8 = 6;
  localparam int SCWC_B_CPU_SUBCLK = 7;
  localparam int SCWC_B_FEEDBACK_OFF = 2;
  localparam int SCWC_B_DIV_LO = 6;
  localparam int SCWC_B_DIV_HI = 7;
  localparam int SCWC_B_WAIT_ENTRY = 0;
  localparam int SCWC_B_WAKE_SEL = 5;
  localparam int SCWC_B_FLASH_STOP = 7;
  localparam int SCWC_B_LOW_CONS = 5;
  localparam int SCWC_B_ST_STABLE = 0;
  localparam int SCWC_B_ST_OSC_ON = 1;
  localparam int SCWC_B_ST_WAIT = 2;
  localparam int SCWC_B_ST_WAKING = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SCWC_RST_CTRL0 = 8'h08;
  localparam logic [7:0] SCWC_RST_CTRL1 = 8'h00;
  localparam logic [7:0] SCWC_RST_CTRL3 = 8'h00;
  localparam logic [7:0] SCWC_RST_FLASH = 8'h00;
  localparam logic [7:0] SCWC_RST_VDET2 = 8'h00;
  localparam logic [2:0] SCWC_RST_IRQ_LVL = 3'h0;
  localparam logic [7:0] SCWC_RST_WAKE_LEN = 8'h10;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [3:0] SCWC_STABLE_EDGES = 4'h8;

  // ****************************************
  // Wait sequencing states
  // ****************************************
  typedef enum logic [1:0] {
    SCWC_RUN = 2'b00,
    SCWC_WAIT = 2'b01,
    SCWC_WAKE = 2'b10
  } scwc_mode_t;

  // Wake clock select to {subclk, div8, div_hi, div_lo}
  function automatic logic [3:0] scwc_wake_clk(input logic [2:0] sel);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      3'h1: r = 4'h1;
      3'h2: r = 4'h2;
      3'h3: r = 4'h3;
      3'h4: r = 4'h4;
      3'h5: r = 4'h8;
      default: r = 4'h0;
    endcase
    return r;
  endfunction : scwc_wake_clk

endpackage : scwc_pkg

// ---- logic/scwc_wake_timer.sv ----
// Wake latency counter: loads a length on start and pulses done when it runs out.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps

module scwc_wake_timer #(
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic [LEN_W-1:0] len,
  // Status
  output logic busy,
  output logic done
);
  import scwc_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [LEN_W-1:0] cnt;
  } scwc_tmr_t;

  scwc_tmr_t st_r;
  scwc_tmr_t st_nxt;

  // Count down from the loaded length; a zero length acts as one cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = (len == '0) ? LEN_W'(1) : len;
    end else if (st_r.busy) begin
      if (st_r.cnt == LEN_W'(1)) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
      st_nxt.cnt = st_r.cnt - LEN_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

endmodule : scwc_wake_timer

// ---- logic/scwc_top.sv ----
// Sub-clock oscillator control, CPU clock selection and wait mode entry and exit.
// Assumes a same-clock register port, same-clock interrupt requests and stop mode
// indication, and a sub-clock input pin that is asynchronous to clk.
`timescale 1ns/1ps

module scwc_top #(
  parameter int NUM_IRQ = 4,
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Sub-clock oscillator pins
  input wire logic subclk_in_pin,
  output logic subclk_out_pin,
  output logic subclk_out_oe,
  // Oscillator analog controls
  output logic subclk_osc_en,
  output logic subclk_feedback_en,
  // Power mode
  input wire logic stop_mode,
  // Peripheral interrupts
  input wire logic [NUM_IRQ-1:0] irq_req,
  output logic [NUM_IRQ-1:0] irq_enabled,
  output logic irq_service,
  // Clock selection and gating
  output logic cpu_subclk_sel,
  output logic cpu_div_8,
  output logic [1:0] cpu_div_sel,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic subclk_clk_en,
  output logic wait_active
);
  import scwc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    // Clock control bits written by software
    logic subclk_stop;
    logic subclk_pin_select;
    logic cpu_div_8_select;
    logic cpu_subclk_select;
    logic subclk_feedback_off;
    logic cpu_div_sel_lo;
    logic cpu_div_sel_hi;
    logic [2:0] wake_clock_sel;

    // Wake latency selection, priority levels and lengths
    logic flash_power_stop;
    logic internal_low_consumption;
    logic [NUM_IRQ*3-1:0] irq_level;
    logic [4*LEN_W-1:0] wake_len;

    // Sequencer state and registered read data
    scwc_mode_t mode;
    logic [7:0] rdata;

    // Pin synchroniser, edge history and stability detector
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic [3:0] edge_cnt;
    logic stable;
    logic service;
  } scwc_state_t;

  scwc_state_t st_r;
  scwc_state_t st_nxt;

  // ****************************************
  // Derived signals
  // ****************************************
  // Oscillator and wake requests
  logic osc_run;
  logic any_wake;

  // Latency counter handshake and selection
  logic tmr_start;
  logic tmr_busy;
  logic tmr_done;
  logic [1:0] len_idx;
  logic [LEN_W-1:0] sel_len;
  logic [3:0] wake_clk;

  // Read images of the registers
  logic [7:0] ctrl0_val;
  logic [7:0] ctrl1_val;
  logic [7:0] ctrl3_val;
  logic [7:0] status_val;

  // Oscillator runs only when enabled by software and not in stop mode
  assign osc_run = st_r.subclk_pin_select & ~st_r.subclk_stop & ~stop_mode;

  // A source with level 000b neither requests service nor wakes the CPU
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
      assign irq_enabled[gi] = irq_req[gi] & (st_r.irq_level[gi*3 +: 3] != 3'h0);
    end
  endgenerate

  assign any_wake = |irq_enabled;

  // Wake latency length picked by flash stop and low consumption bits
  assign len_idx = {st_r.flash_power_stop, st_r.internal_low_consumption};
  assign sel_len = st_r.wake_len[len_idx*LEN_W +: LEN_W];
  // Latency counter starts on the WAIT to WAKE step
  assign tmr_start = (st_r.mode == SCWC_WAIT) & any_wake;

  // Clock bits that the wake selection stands for
  assign wake_clk = scwc_wake_clk(st_r.wake_clock_sel);

  // Register images for reads
  always_comb begin
    // Control 0: oscillator, pin function and CPU source
    ctrl0_val = 8'h00;
    ctrl0_val[SCWC_B_SUBCLK_STOP] = st_r.subclk_stop;
    ctrl0_val[SCWC_B_SUBCLK_PIN_SEL] = st_r.subclk_pin_select;
    ctrl0_val[SCWC_B_CPU_DIV8] = st_r.cpu_div_8_select;
    ctrl0_val[SCWC_B_CPU_SUBCLK] = st_r.cpu_subclk_select;

    // Control 1: feedback resistor and division bits
    ctrl1_val = 8'h00;
    ctrl1_val[SCWC_B_FEEDBACK_OFF] = st_r.subclk_feedback_off;
    ctrl1_val[SCWC_B_DIV_LO] = st_r.cpu_div_sel_lo;
    ctrl1_val[SCWC_B_DIV_HI] = st_r.cpu_div_sel_hi;

    // Control 3: wait entry reads 1 until the CPU runs again
    ctrl3_val = 8'h00;
    ctrl3_val[SCWC_B_WAIT_ENTRY] = (st_r.mode != SCWC_RUN);
    ctrl3_val[SCWC_B_WAKE_SEL +: 3] = st_r.wake_clock_sel;

    // Status: stability, oscillator and sequencer state
    status_val = 8'h00;
    status_val[SCWC_B_ST_STABLE] = st_r.stable;
    status_val[SCWC_B_ST_OSC_ON] = osc_run;
    status_val[SCWC_B_ST_WAIT] = (st_r.mode == SCWC_WAIT);
    status_val[SCWC_B_ST_WAKING] = (st_r.mode == SCWC_WAKE);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    int unsigned idx;
    idx = 0;
    st_nxt = st_r;
    st_nxt.service = 1'b0;
    st_nxt.rdata = 8'h00;

    // The wait sequencer runs last, so a wake reload of the clock
    // bits overrides a register write landing in the same cycle

    // Pin synchroniser and activity detector
    // Only the second flop feeds logic; the third is edge history
    st_nxt.pin_s1 = subclk_in_pin;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.pin_s3 = st_r.pin_s2;
    // Stability is lost whenever the oscillator stops
    if (!osc_run) begin
      st_nxt.edge_cnt = 4'h0;
      st_nxt.stable = 1'b0;
    end else if (st_r.pin_s2 & ~st_r.pin_s3 & ~st_r.stable) begin
      st_nxt.edge_cnt = st_r.edge_cnt + 4'h1;
      if (st_r.edge_cnt + 4'h1 >= SCWC_STABLE_EDGES) begin
        st_nxt.stable = 1'b1;
      end
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        // Oscillator enable, pin function and CPU source
        SCWC_OFS_CTRL0: begin
          st_nxt.subclk_stop = reg_wdata[SCWC_B_SUBCLK_STOP];
          st_nxt.subclk_pin_select = reg_wdata[SCWC_B_SUBCLK_PIN_SEL];
          st_nxt.cpu_div_8_select = reg_wdata[SCWC_B_CPU_DIV8];
          st_nxt.cpu_subclk_select = reg_wdata[SCWC_B_CPU_SUBCLK];
        end

        // Feedback resistor control and division bits
        SCWC_OFS_CTRL1: begin
          st_nxt.subclk_feedback_off = reg_wdata[SCWC_B_FEEDBACK_OFF];
          st_nxt.cpu_div_sel_lo = reg_wdata[SCWC_B_DIV_LO];
          st_nxt.cpu_div_sel_hi = reg_wdata[SCWC_B_DIV_HI];
        end

        // Wake clock selection; wait entry is refused unless running
        SCWC_OFS_CTRL3: begin
          st_nxt.wake_clock_sel = reg_wdata[SCWC_B_WAKE_SEL +: 3];
          if (reg_wdata[SCWC_B_WAIT_ENTRY] && st_r.mode == SCWC_RUN) begin
            st_nxt.mode = SCWC_WAIT;
          end
        end

        // Flash power stop picks half of the latency table
        SCWC_OFS_FLASH: begin
          st_nxt.flash_power_stop = reg_wdata[SCWC_B_FLASH_STOP];
        end

        // Low consumption picks the other half
        SCWC_OFS_VDET2: begin
          st_nxt.internal_low_consumption = reg_wdata[SCWC_B_LOW_CONS];
        end

        // Priority levels, then latency lengths; other writes are ignored
        default: begin
          if (reg_addr >= SCWC_OFS_IRQ_LVL && reg_addr < SCWC_OFS_IRQ_LVL + 8'(NUM_IRQ)) begin
            idx = 32'(reg_addr - SCWC_OFS_IRQ_LVL);
            st_nxt.irq_level[idx*3 +: 3] = reg_wdata[2:0];
          end else if (reg_addr >= SCWC_OFS_WAKE_LEN && reg_addr < SCWC_OFS_WAKE_LEN + 8'h04) begin
            idx = 32'(reg_addr - SCWC_OFS_WAKE_LEN);
            st_nxt.wake_len[idx*LEN_W +: LEN_W] = LEN_W'(reg_wdata);
          end
        end
      endcase
    end

    // Register reads, answered in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        SCWC_OFS_CTRL0: st_nxt.rdata = ctrl0_val;
        SCWC_OFS_CTRL1: st_nxt.rdata = ctrl1_val;
        SCWC_OFS_CTRL3: st_nxt.rdata = ctrl3_val;
        SCWC_OFS_FLASH: st_nxt.rdata = 8'(st_r.flash_power_stop) << SCWC_B_FLASH_STOP;
        SCWC_OFS_VDET2: st_nxt.rdata = 8'(st_r.internal_low_consumption) << SCWC_B_LOW_CONS;
        // Status is read-only; a write to it is ignored
        SCWC_OFS_STATUS: st_nxt.rdata = status_val;
        default: begin
          if (reg_addr >= SCWC_OFS_IRQ_LVL && reg_addr < SCWC_OFS_IRQ_LVL + 8'(NUM_IRQ)) begin
            idx = 32'(reg_addr - SCWC_OFS_IRQ_LVL);
            st_nxt.rdata = {5'h00, st_r.irq_level[idx*3 +: 3]};
          end else if (reg_addr >= SCWC_OFS_WAKE_LEN && reg_addr < SCWC_OFS_WAKE_LEN + 8'h04) begin
            idx = 32'(reg_addr - SCWC_OFS_WAKE_LEN);
            st_nxt.rdata = 8'(st_r.wake_len[idx*LEN_W +: LEN_W]);
          end
          // Any other address reads as zero
        end
      endcase
    end

    // Wait sequencing
    case (st_r.mode)
      // Running: entry comes from the register write above
      SCWC_RUN: begin
      end

      // Waiting: the first enabled request starts the latency counter
      SCWC_WAIT: begin
        if (any_wake) begin
          st_nxt.mode = SCWC_WAKE;
        end
      end

      // Waking: on done resume, pulse service and reload the clock bits
      SCWC_WAKE: begin
        if (tmr_done) begin
          st_nxt.mode = SCWC_RUN;
          st_nxt.service = 1'b1;
          st_nxt.cpu_subclk_select = wake_clk[3];
          st_nxt.cpu_div_8_select = wake_clk[2];
          st_nxt.cpu_div_sel_hi = wake_clk[1];
          st_nxt.cpu_div_sel_lo = wake_clk[0];
        end
      end

      // Unused code falls back to running
      default: begin
        st_nxt.mode = SCWC_RUN;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Clear everything, then load the named reset values
      st_r <= '0;

      // Oscillator stopped and pin function off until software acts
      st_r.subclk_stop <= SCWC_RST_CTRL0[SCWC_B_SUBCLK_STOP];
      st_r.subclk_pin_select <= SCWC_RST_CTRL0[SCWC_B_SUBCLK_PIN_SEL];

      // CPU source, feedback and division bits
      st_r.cpu_div_8_select <= SCWC_RST_CTRL0[SCWC_B_CPU_DIV8];
      st_r.cpu_subclk_select <= SCWC_RST_CTRL0[SCWC_B_CPU_SUBCLK];
      st_r.subclk_feedback_off <= SCWC_RST_CTRL1[SCWC_B_FEEDBACK_OFF];
      st_r.cpu_div_sel_lo <= SCWC_RST_CTRL1[SCWC_B_DIV_LO];
      st_r.cpu_div_sel_hi <= SCWC_RST_CTRL1[SCWC_B_DIV_HI];

      // Wake selection, latency choice, levels and lengths
      st_r.wake_clock_sel <= SCWC_RST_CTRL3[SCWC_B_WAKE_SEL +: 3];
      st_r.flash_power_stop <= SCWC_RST_FLASH[SCWC_B_FLASH_STOP];
      st_r.internal_low_consumption <= SCWC_RST_VDET2[SCWC_B_LOW_CONS];
      st_r.irq_level <= {NUM_IRQ{SCWC_RST_IRQ_LVL}};
      st_r.wake_len <= {4{LEN_W'(SCWC_RST_WAKE_LEN)}};

      // Sequencer starts in the running state
      st_r.mode <= SCWC_RUN;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Wake latency counter
  // ****************************************
  // Start is the WAIT to WAKE pulse; done ends the latency
  scwc_wake_timer #(
    .LEN_W(LEN_W)
  ) scwc_wake_timer_inst (
    .clk(clk),
    .rst(rst),
    .start(tmr_start),
    .len(sel_len),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // Oscillator amplifier drives the return pin only while running
  assign subclk_osc_en = osc_run;
  assign subclk_out_oe = osc_run;
  assign subclk_out_pin = osc_run & ~st_r.pin_s2;
  // Feedback resistor follows its bit while the pin function is on and is always cut in stop mode
  assign subclk_feedback_en = st_r.subclk_pin_select & ~st_r.subclk_feedback_off & ~stop_mode;

  // Clock selection from registers
  assign cpu_subclk_sel = st_r.cpu_subclk_select;
  assign cpu_div_8 = st_r.cpu_div_8_select;
  assign cpu_div_sel = {st_r.cpu_div_sel_hi, st_r.cpu_div_sel_lo};

  // Gating: CPU halts in wait, everything halts in stop
  assign cpu_clk_en = (st_r.mode == SCWC_RUN) & ~stop_mode;
  assign periph_clk_en = ~stop_mode;
  // Sub-clock users wait for a stable oscillator; stop mode cuts it too
  assign subclk_clk_en = osc_run & st_r.stable;

  // Status and data outputs from the state flip-flops
  assign wait_active = (st_r.mode != SCWC_RUN);
  assign irq_service = st_r.service;
  assign reg_rdata = st_r.rdata;

endmodule : scwc_top

// ---- verif/scwc_monitor.sv ----
// Port checker for the sub-clock and wait control block.
// Assumes one clock domain, reset active high and the block's register map package.
`timescale 1ns/1ps

module scwc_monitor
  import scwc_pkg::*;
#(
  parameter int NUM_IRQ = 4,
  parameter int LEN_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Oscillator and power
  input wire logic subclk_osc_en,
  input wire logic subclk_feedback_en,
  input wire logic stop_mode,
  // Interrupts and clocks
  input wire logic [NUM_IRQ-1:0] irq_req,
  input wire logic [NUM_IRQ-1:0] irq_enabled,
  input wire logic irq_service,
  input wire logic cpu_subclk_sel,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic subclk_clk_en,
  input wire logic wait_active
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_osc_reset; $fell(rst) |-> !subclk_osc_en; endproperty
  property p_osc_start;
    (reg_wr && reg_addr == SCWC_OFS_CTRL0 && reg_wdata[SCWC_B_SUBCLK_PIN_SEL] && !reg_wdata[SCWC_B_SUBCLK_STOP])
      ##1 !stop_mode |-> subclk_osc_en;
  endproperty
  property p_cpu_sel;
    reg_wr && reg_addr == SCWC_OFS_CTRL0 && !wait_active |=> cpu_subclk_sel == $past(reg_wdata[SCWC_B_CPU_SUBCLK]);
  endproperty
  property p_stop_fb; stop_mode |-> !subclk_feedback_en; endproperty
  property p_fb_off;
    reg_wr && reg_addr == SCWC_OFS_CTRL1 && reg_wdata[SCWC_B_FEEDBACK_OFF] |=> !subclk_feedback_en;
  endproperty
  property p_stop_clk; stop_mode |-> !subclk_osc_en && !cpu_clk_en && !periph_clk_en; endproperty
  property p_wait_in;
    reg_wr && reg_addr == SCWC_OFS_CTRL3 && reg_wdata[SCWC_B_WAIT_ENTRY] && !wait_active |=> wait_active && !cpu_clk_en;
  endproperty
  property p_irq_mask; (irq_enabled & ~irq_req) == '0; endproperty
  property p_wake_bound; wait_active && (|irq_enabled) |-> ##[1:258] irq_service; endproperty
  property p_svc; irq_service |-> !wait_active && $past(wait_active) ##1 !irq_service; endproperty
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty

  // ****************************************
  // Assertions and covers
  // ****************************************
  a_osc_reset: assert property (p_osc_reset) else $error("oscillator enabled after reset");
  a_osc_start: assert property (p_osc_start) else $error("oscillator did not start");
  a_cpu_sel: assert property (p_cpu_sel) else $error("cpu clock source not updated");
  a_stop_fb: assert property (p_stop_fb) else $error("feedback connected in stop mode");
  a_fb_off: assert property (p_fb_off) else $error("feedback ignores its control bit");
  a_stop_clk: assert property (p_stop_clk) else $error("clock running in stop mode");
  a_wait_in: assert property (p_wait_in) else $error("wait mode not entered");
  a_irq_mask: assert property (p_irq_mask) else $error("enabled without request");
  a_wake_bound: assert property (p_wake_bound) else $error("wake took too long");
  a_svc: assert property (p_svc) else $error("service pulse out of place");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  c_wake: cover property (wait_active ##1 irq_service);
  c_stop: cover property (stop_mode);
  c_stable: cover property ($rose(subclk_clk_en));
endmodule : scwc_monitor

bind scwc_top scwc_monitor #(.NUM_IRQ(NUM_IRQ), .LEN_W(LEN_W)) scwc_monitor_inst (.clk, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .subclk_osc_en, .subclk_feedback_en, .stop_mode, .irq_req,
  .irq_enabled, .irq_service, .cpu_subclk_sel, .cpu_clk_en, .periph_clk_en, .subclk_clk_en, .wait_active);

// ---- verif/scwc_xtal_model.sv ----
// Behavioural resonator or external clock source on the sub-clock input pin.
// Assumes the design's oscillator enable, pin drive enable and feedback enable.
`timescale 1ns/1ps

module scwc_xtal_model #(
  parameter int HALF_NS = 40
) (
  // Design side
  input wire logic osc_en,
  input wire logic drive_oe,
  input wire logic fb_en,
  // Test control
  input wire logic ext_mode,
  // Pin
  output logic xin
);
  // Resonator swings only with drive and feedback; an external source runs on its own
  initial xin = 1'b0;
  always begin
    if ((osc_en && drive_oe && fb_en) || ext_mode) begin
      #(HALF_NS) xin = ~xin;
    end else begin
      xin = 1'b0; // Quiet resonator settles low
      @(osc_en or drive_oe or fb_en or ext_mode);
    end
  end
endmodule : scwc_xtal_model

// ---- verif/scwc_top_tb_top.sv ----
// Self-checking bench for the sub-clock and wait control block.
// Assumes the register map package and a 200 MHz clock.
`timescale 1ns/1ps

module scwc_top_tb_top;
  import scwc_pkg::*;
  typedef struct {logic [3:0] bits; int len; int start;} scwc_note_t;

  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0, ext_mode = 1'b0, rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] irq_req = 4'h0, irq_enabled;
  logic [1:0] cpu_div_sel;
  logic subclk_in_pin, subclk_out_pin, subclk_out_oe, subclk_osc_en, subclk_feedback_en, irq_service;
  logic cpu_subclk_sel, cpu_div_8, cpu_clk_en, periph_clk_en, subclk_clk_en, wait_active;
  logic [3:0] wmap [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
  int num_errors = 0, check_count = 0, cyc = 0, off0 = -1, combo, len, tgt;
  logic [7:0] rd_q [$];
  scwc_note_t wk_q [$];
  scwc_note_t n;

  scwc_top #(.NUM_IRQ(4), .LEN_W(8)) scwc_top_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .subclk_in_pin, .subclk_out_pin, .subclk_out_oe, .subclk_osc_en, .subclk_feedback_en,
    .stop_mode, .irq_req, .irq_enabled, .irq_service, .cpu_subclk_sel, .cpu_div_8, .cpu_div_sel, .cpu_clk_en,
    .periph_clk_en, .subclk_clk_en, .wait_active);
  scwc_xtal_model scwc_xtal_model_inst (.osc_en(subclk_osc_en), .drive_oe(subclk_out_oe),
    .fb_en(subclk_feedback_en), .ext_mode, .xin(subclk_in_pin));

  // ****************************************
  // Clock, cycle count and tasks
  // ****************************************
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Read data are taken the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(reg_rdata, rd_q.pop_front(), "read");
    rd_d = reg_rd;
  end

  // Each service pulse is matched with the oldest wake note
  always @(posedge clk) begin
    if (irq_service === 1'b1) begin
      chk({7'h0, wk_q.size() > 0}, 8'h01, "unexpected wake");
      n = wk_q.pop_front();
      chk({4'h0, cpu_subclk_sel, cpu_div_8, cpu_div_sel}, {4'h0, n.bits}, "wake clock");
      if (off0 < 0) off0 = cyc - n.start - n.len;
      chk(8'(cyc - n.start - n.len), 8'(off0), "wake delay");
      chk(8'(off0), 8'h03, "wake offset");
    end
  end

  // Watchdog
  initial begin
    #(40000 * 5);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(22));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({5'h0, subclk_osc_en, subclk_out_oe, subclk_out_pin}, 8'h00, "osc after reset");
    rd(SCWC_OFS_CTRL0, SCWC_RST_CTRL0);
    rd(SCWC_OFS_CTRL1, SCWC_RST_CTRL1);
    rd(SCWC_OFS_CTRL3, SCWC_RST_CTRL3);
    rd(SCWC_OFS_STATUS, 8'h00);
    rd(SCWC_OFS_WAKE_LEN, SCWC_RST_WAKE_LEN);
    wr(8'h07, 8'hff);
    rd(8'h07, 8'h00);
    $display("test reset done");
    // External clock with feedback off, then resonator with feedback on
    ext_mode <= 1'b1;
    wr(SCWC_OFS_CTRL1, 8'h04);
    wr(SCWC_OFS_CTRL0, 8'h10);
    @(posedge clk);
    chk({7'h0, subclk_osc_en}, 8'h01, "osc start");
    chk({7'h0, subclk_out_oe}, 8'h01, "return drive on");
    chk({7'h0, subclk_feedback_en}, 8'h00, "feedback off");
    for (int k = 0; k < 400 && subclk_clk_en !== 1'b1; k++) @(posedge clk);
    rd(SCWC_OFS_STATUS, 8'h03);
    ext_mode <= 1'b0;
    wr(SCWC_OFS_CTRL1, 8'h00);
    @(posedge clk);
    chk({7'h0, subclk_feedback_en}, 8'h01, "feedback on");
    wr(SCWC_OFS_CTRL0, 8'h90);
    @(posedge clk);
    chk({7'h0, cpu_subclk_sel}, 8'h01, "cpu on subclock");
    $display("test oscillator done");
    // Stop mode
    stop_mode <= 1'b1;
    @(posedge clk);
    chk({4'h0, subclk_osc_en, subclk_feedback_en, cpu_clk_en, periph_clk_en}, 8'h00, "stop");
    chk({5'h0, subclk_clk_en, subclk_out_oe, subclk_out_pin}, 8'h00, "pins in stop");
    stop_mode <= 1'b0;
    $display("test stop done");
    // Wake by select codes 0 to 5 over every latency combination
    for (int i = 0; i < 6; i++) begin
      combo = i % 4;
      len = 2 + $urandom % 6;
      tgt = $urandom % 4;
      wr(SCWC_OFS_FLASH, {combo[1], 7'h0});
      wr(SCWC_OFS_VDET2, {2'h0, combo[0], 5'h0});
      wr(SCWC_OFS_WAKE_LEN + 8'(combo), 8'(len));
      for (int j = 0; j < 4; j++) wr(SCWC_OFS_IRQ_LVL + 8'(j), (j == tgt) ? 8'(1 + $urandom % 7) : 8'h00);
      wr(SCWC_OFS_CTRL3, {3'(i), 4'h0, 1'b1});
      rd(SCWC_OFS_CTRL3, {3'(i), 4'h0, 1'b1});
      irq_req <= 4'($urandom) & ~(4'h1 << tgt);
      repeat (4) @(posedge clk);
      chk({4'h0, irq_enabled}, 8'h00, "level zero masked");
      chk({7'h0, wait_active}, 8'h01, "still waiting");
      wk_q.push_back('{wmap[i], len, cyc});
      irq_req <= 4'h1 << tgt;
      for (int k = 0; k < 300 && wait_active !== 1'b0; k++) @(posedge clk);
      irq_req <= 4'h0;
    end
    repeat (4) @(posedge clk);
    chk(8'(wk_q.size()), 8'h00, "missing wake");
    $display("test wake done");
    give_verdict();
  end
endmodule : scwc_top_tb_top
